//--- logic/pcs_start_seq.v
// start method selection, cold start sequencing and supply interruption handling
// How it works
// - keep running whatever the host mode
// - ride through short supply dips
// - stop after long supply interruption
// - middle band continues
// - extension time adds to all thresholds
// - healthy memories plus hot setting: hot start
// - healthy memories plus cold setting: full cold
// - bad RAM: error flag, automatic cold start
// - bad flash, backup on: save, then cold
// - bad flash, backup off: stop
// - both bad: error and fatal, stop
// - cold order: flash, host data, init
// - cold start: local, output zero, manual
// - start-mode codes: timed, hot, cold, host
// - restart bit rising edge reruns selection
// - over 24 hours off forces cold in timed and hot modes
// - timed mode hot only within window
`include "pcs_regs.vh"
`default_nettype none
module pcs_start_seq #(
	parameter CYC_PER_MS = `PCS_MS_CYC,
	parameter MS_W       = 18
) (
	// clock and reset
	input  wire        CLOCK,
	input  wire        RST_B,
	// configuration
	input  wire [1:0]  START_MODE_SETTING,
	input  wire        BACKUP_START_OPTION,
	input  wire [11:0] HOT_START_WINDOW,
	input  wire [3:0]  EXT_TIME_MS,
	input  wire        SUPPLY_DC,
	// supply and memory health
	input  wire        SUPPLY_LOW,
	input  wire [16:0] OFF_TIME_S,
	input  wire        RAM_OK,
	input  wire        FLASH_OK,
	// host controller
	input  wire [1:0]  HOST_MODE,
	input  wire        BOARD_RESTART_BIT,
	input  wire        HOST_HOT_REQ,
	input  wire        HOST_COLD_REQ,
	// transfer engine
	output wire        XFER_REQ,
	output reg  [1:0]  XFER_OP,
	input  wire        XFER_DONE,
	output wire        WORK_CLEAR,
	// status out
	output reg         RUNNING,
	output reg         COLD_START_BUSY,
	output reg         RAM_ERROR_FLAG,
	output reg         INNER_BOARD_FATAL_FLAG,
	output reg         AUTO_COLD_START_FLAG,
	output reg         LOCAL_SP_SEL,
	output reg         MANUAL_MODE,
	output reg         MANIPULATED_OUTPUT_ZERO
);
	// sequencer states
	localparam [3:0] ST_SELECT = 4'h0;  // choose start method
	localparam [3:0] ST_BACKUP = 4'h1;  // RAM written back to flash
	localparam [3:0] ST_FLASH  = 4'h2;  // flash copied into RAM
	localparam [3:0] ST_HOST   = 4'h3;  // host data copied into RAM
	localparam [3:0] ST_INIT   = 4'h4;  // working area cleared
	localparam [3:0] ST_RUN    = 4'h5;  // control running
	localparam [3:0] ST_STOP   = 4'h6;  // stopped, waits for restart
	localparam [3:0] ST_PWRDN  = 4'h7;  // stopped by supply loss
	localparam [3:0] ST_WAIT   = 4'h8;  // waits for host choice

	reg  [3:0] state_q;      // current state
	reg  [3:0] state_d;      // next state
	reg  [1:0] op_d;         // next transfer operation
	reg        restart_q;    // last restart bit level
	reg        ram_err_d;    // next RAM error flag
	reg        fatal_d;      // next fatal flag
	reg        auto_d;       // next automatic cold flag
	wire       restart_rise; // restart bit went high
	wire       ms_tick;      // one pulse per millisecond
	wire [5:0] dip_ms;       // length of current dip in ms
	wire [3:0] ext_ms;       // clamped extension time
	wire [5:0] stop_ms;      // dip length that forces a stop
	wire       dip_stop;     // supply interruption too long
	wire       over_day;     // off longer than a day
	wire       over_win;     // off longer than hot window
	wire [11:0] win_s;       // clamped hot window

	// millisecond time base
	pcs_tick_div #(
		.PERIOD (CYC_PER_MS),
		.W      (MS_W)
	) u_ms (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.tick  (ms_tick)
	);

	// length of the present supply dip, cleared when supply is good
	pcs_sat_cnt #(
		.W (6)
	) u_dip (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.clr   (~SUPPLY_LOW),
		.inc   (ms_tick),
		.cnt_q (dip_ms)
	);

	// extension time saturates at its top setting
	assign ext_ms = (EXT_TIME_MS > `PCS_EXT_MAX_MS) ? `PCS_EXT_MAX_MS : EXT_TIME_MS;

	// stop point is the upper threshold, so the middle band continues
	assign stop_ms = (SUPPLY_DC ? `PCS_DC_STOP_MS : `PCS_AC_STOP_MS) + {2'h0, ext_ms};
	assign dip_stop = SUPPLY_LOW && (dip_ms >= stop_ms);
	// dips shorter than stop_ms keep running, covering the sure band

	// start-time comparisons on the off duration
	assign over_day = (OFF_TIME_S > `PCS_HOT_LIMIT_S);
	assign win_s    = (HOT_START_WINDOW > `PCS_WINDOW_MAX_S) ? `PCS_WINDOW_MAX_S : HOT_START_WINDOW;
	assign over_win = (OFF_TIME_S > {5'h00, win_s});

	// restart is taken on the rising edge only
	assign restart_rise = BOARD_RESTART_BIT & ~restart_q;

	// handshake strobes decoded from the state
	assign XFER_REQ   = (state_q == ST_BACKUP) || (state_q == ST_FLASH) || (state_q == ST_HOST);
	assign WORK_CLEAR = (state_q == ST_INIT);

	// next state and flags
	always @* begin
		state_d   = state_q;
		ram_err_d = RAM_ERROR_FLAG;
		fatal_d   = INNER_BOARD_FATAL_FLAG;
		auto_d    = AUTO_COLD_START_FLAG;
		// host mode never enters the decision
		if (dip_stop && (state_q != ST_PWRDN)) begin
			state_d = ST_PWRDN;
		end else if (restart_rise && (state_q != ST_PWRDN)) begin
			state_d = ST_SELECT;
		end else begin
			case (state_q)
				ST_SELECT: begin
					// flags rewritten only here, then held
					ram_err_d = 1'b0;
					fatal_d   = 1'b0;
					auto_d    = 1'b0;
					if (!RAM_OK && !FLASH_OK) begin
						ram_err_d = 1'b1;
						fatal_d   = 1'b1;
						auto_d    = 1'b1;
						state_d   = ST_STOP;
					end else if (!RAM_OK) begin
						ram_err_d = 1'b1;
						auto_d    = 1'b1;
						state_d   = ST_FLASH;
					end else if (!FLASH_OK) begin
						if (BACKUP_START_OPTION) begin
							auto_d  = 1'b1;
							state_d = ST_BACKUP;
						end else begin
							state_d = ST_STOP;
						end
					end else begin
						case (START_MODE_SETTING)
							`PCS_MODE_TIMED: begin
								// past the window but within a day: short cold, RAM contents kept
								if (over_day) begin
									state_d = ST_FLASH;
								end else if (over_win) begin
									state_d = ST_INIT;
								end else begin
									state_d = ST_RUN;
								end
							end
							`PCS_MODE_HOT: begin
								if (over_day) begin
									state_d = ST_FLASH;
								end else begin
									state_d = ST_RUN;
								end
							end
							`PCS_MODE_COLD: begin
								state_d = ST_FLASH;
							end
							`PCS_MODE_HOST: begin
								state_d = ST_WAIT;
							end
							default: begin
								state_d = ST_STOP;
							end
						endcase
					end
				end
				ST_WAIT: begin
					// host picks; cold wins when both are asked
					if (HOST_COLD_REQ) begin
						state_d = ST_FLASH;
					end else if (HOST_HOT_REQ) begin
						state_d = ST_RUN;
					end
				end
				ST_BACKUP: begin
					if (XFER_DONE) begin
						state_d = ST_FLASH;
					end
				end
				ST_FLASH: begin
					if (XFER_DONE) begin
						state_d = ST_HOST;
					end
				end
				ST_HOST: begin
					if (XFER_DONE) begin
						state_d = ST_INIT;
					end
				end
				ST_INIT: begin
					state_d = ST_RUN;
				end
				ST_RUN: begin
					state_d = ST_RUN;
				end
				ST_STOP: begin
					// left by a host restart after download or by a long supply dip
					state_d = ST_STOP;
				end
				ST_PWRDN: begin
					// supply back: same path as power-on
					if (!SUPPLY_LOW) begin
						state_d = ST_SELECT;
					end
				end
				default: begin
					state_d = ST_SELECT;
				end
			endcase
		end
	end

	// transfer operation for the state being entered
	always @* begin
		case (state_d)
			ST_BACKUP: begin
				op_d = `PCS_OP_RAM2FLASH;
			end
			ST_FLASH: begin
				op_d = `PCS_OP_FLASH2RAM;
			end
			ST_HOST: begin
				op_d = `PCS_OP_HOST2RAM;
			end
			default: begin
				op_d = `PCS_OP_NONE;
			end
		endcase
	end

	// sequencer and flag registers
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_q                <= ST_SELECT;
			XFER_OP                <= `PCS_OP_NONE;
			restart_q              <= 1'b0;
			RAM_ERROR_FLAG         <= 1'b0;
			INNER_BOARD_FATAL_FLAG <= 1'b0;
			AUTO_COLD_START_FLAG   <= 1'b0;
		end else begin
			state_q                <= state_d;
			XFER_OP                <= op_d;
			restart_q              <= BOARD_RESTART_BIT;
			RAM_ERROR_FLAG         <= ram_err_d;
			INNER_BOARD_FATAL_FLAG <= fatal_d;
			AUTO_COLD_START_FLAG   <= auto_d;
		end
	end

	// run state, cold-start busy and control start conditions
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			RUNNING                 <= 1'b0;
			COLD_START_BUSY         <= 1'b0;
			LOCAL_SP_SEL            <= 1'b1;
			MANUAL_MODE             <= 1'b1;
			MANIPULATED_OUTPUT_ZERO <= 1'b1;
		end else begin
			RUNNING         <= (state_d == ST_RUN);
			COLD_START_BUSY <= (state_d == ST_BACKUP) || (state_d == ST_FLASH) ||
			                   (state_d == ST_HOST) || (state_d == ST_INIT);
			// hot start leaves these as they were
			if (state_q == ST_INIT) begin
				LOCAL_SP_SEL            <= 1'b1;
				MANUAL_MODE             <= 1'b1;
				MANIPULATED_OUTPUT_ZERO <= 1'b1;
			end
		end
	end

	// host mode is deliberately unused
	wire unused_host_mode = ^HOST_MODE;
endmodule
`default_nettype wire

//--- logic/pcs_regs.vh
// constants for the power-on start sequencer
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// start-mode setting encodings
`define PCS_MODE_TIMED     2'h0
`define PCS_MODE_HOT       2'h1
`define PCS_MODE_COLD      2'h2
`define PCS_MODE_HOST      2'h3

// transfer engine operations
`define PCS_OP_NONE        2'h0
`define PCS_OP_FLASH2RAM   2'h1
`define PCS_OP_HOST2RAM    2'h2
`define PCS_OP_RAM2FLASH   2'h3

// clock and millisecond timing
`define PCS_CLK_PERIOD_NS  4
`define PCS_TIME_1MS_NS    1000000
`define PCS_MS_CYC         (`PCS_TIME_1MS_NS / `PCS_CLK_PERIOD_NS)

// supply interruption thresholds in ms
`define PCS_AC_CONT_MS     6'h0A
`define PCS_AC_STOP_MS     6'h19
`define PCS_DC_CONT_MS     6'h02
`define PCS_DC_STOP_MS     6'h05
`define PCS_EXT_MAX_MS     4'hA

// off-time limits in seconds
`define PCS_HOT_LIMIT_S    17'h15180
`define PCS_WINDOW_MAX_S   12'hE10

`endif

//--- logic/pcs_tick_div.v
// free-running divider giving one pulse every PERIOD clocks
`default_nettype none
module pcs_tick_div #(
	parameter PERIOD = 250000,
	parameter W      = 18
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_b,
	// one-cycle tick out
	output wire         tick
);
	reg [W-1:0] cnt_q;   // cycle counter
	reg [W-1:0] cnt_d;   // next count

	// wrap at the end of the period
	always @* begin
		if (cnt_q == PERIOD[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
			cnt_d = {W{1'b0}};
		end else begin
			cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// counter register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= {W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = (cnt_q == PERIOD[W-1:0] - {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

//--- logic/pcs_sat_cnt.v
// saturating event counter with synchronous clear
`default_nettype none
module pcs_sat_cnt #(
	parameter W = 6
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_b,
	// control
	input  wire         clr,
	input  wire         inc,
	// count out
	output reg  [W-1:0] cnt_q
);
	// clear wins, then count up to all ones and hold
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= {W{1'b0}};
		end else if (clr) begin
			cnt_q <= {W{1'b0}};
		end else if (inc && (cnt_q != {W{1'b1}})) begin
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

//--- logic/pcs_placeholder_none.v
`default_nettype none
`default_nettype wire

//--- verification/pcs_xfer_model.sv
// transfer engine and host data area stand-in for the start sequencer
`default_nettype none
module pcs_xfer_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// transfer handshake
	input  wire logic       req,
	input  wire logic [1:0] op,
	output var  logic       done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q; // cycles spent on current transfer
	// flash copies answer promptly, host data copy answers slowly
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
			done  <= 1'b0;
		end else if (done || !req) begin
			cnt_q <= 3'h0;
			done  <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			done  <= (cnt_q == ((op == 2'h2) ? 3'h5 : 3'h0));
		end
	end
endmodule
`default_nettype wire

//--- verification/pcs_seq_asserts.sv
// assertion checker for the power-on start sequencer
`include "pcs_regs.vh"
`default_nettype none
module pcs_seq_chk #(
	parameter CYC_PER_MS = `PCS_MS_CYC
) (
	// clock and reset
	input wire logic       CLOCK,
	input wire logic       RST_B,
	// supply
	input wire logic [3:0] EXT_TIME_MS,
	input wire logic       SUPPLY_DC,
	input wire logic       SUPPLY_LOW,
	// transfer engine
	input wire logic       XFER_REQ,
	input wire logic [1:0] XFER_OP,
	input wire logic       XFER_DONE,
	input wire logic       WORK_CLEAR,
	// status
	input wire logic       RUNNING,
	input wire logic       COLD_START_BUSY,
	input wire logic       RAM_ERROR_FLAG,
	input wire logic       INNER_BOARD_FATAL_FLAG,
	input wire logic       LOCAL_SP_SEL,
	input wire logic       MANUAL_MODE,
	input wire logic       MANIPULATED_OUTPUT_ZERO
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	logic [15:0] low_q;    // consecutive low-supply cycles
	int          stop_lim; // cycles after which a stop is certain
	int          cont_lim; // cycles below which running must go on
	logic        fin;      // a transfer ends this cycle
	assign stop_lim = ((SUPPLY_DC ? 5 : 25) + EXT_TIME_MS + 1) * CYC_PER_MS + 2;
	assign cont_lim = ((SUPPLY_DC ? 2 : 10) + EXT_TIME_MS) * CYC_PER_MS;
	assign fin = XFER_REQ && XFER_DONE;
	// measure the current supply dip
	always @(posedge CLOCK or negedge RST_B)
		if (!RST_B)
			low_q <= 16'h0000;
		else
			low_q <= SUPPLY_LOW ? low_q + 16'h0001 : 16'h0000;
	dip_stop_a: assert property (low_q > stop_lim |-> !RUNNING)
		else $error("running after long supply dip");
	dip_ride_a: assert property ($fell(RUNNING) && SUPPLY_LOW |-> low_q >= cont_lim)
		else $error("stopped on short supply dip");
	fatal_stop_a: assert property (INNER_BOARD_FATAL_FLAG |-> RAM_ERROR_FLAG && !RUNNING && !XFER_REQ)
		else $error("fatal error without stop");
	cold_init_a: assert property (WORK_CLEAR |=> RUNNING && LOCAL_SP_SEL && MANUAL_MODE && MANIPULATED_OUTPUT_ZERO)
		else $error("cold start state wrong");
	op_order_a: assert property (fin && XFER_OP == `PCS_OP_FLASH2RAM |=> XFER_REQ && XFER_OP == `PCS_OP_HOST2RAM)
		else $error("host copy not after flash copy");
	host_done_a: assert property (fin && XFER_OP == `PCS_OP_HOST2RAM |=> WORK_CLEAR ##1 RUNNING)
		else $error("no init after host copy");
	backup_first_a: assert property (fin && XFER_OP == `PCS_OP_RAM2FLASH |=> XFER_OP == `PCS_OP_FLASH2RAM)
		else $error("no flash copy after backup");
	busy_xfer_a: assert property (XFER_REQ |-> COLD_START_BUSY && !RUNNING)
		else $error("transfer while not busy");
endmodule
bind pcs_start_seq pcs_seq_chk #(.CYC_PER_MS(CYC_PER_MS)) pcs_seq_chk_i (.*);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the power-on start sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLOCK, RST_B, SUPPLY_DC, SUPPLY_LOW, RAM_OK, FLASH_OK, BACKUP_START_OPTION;
	logic        BOARD_RESTART_BIT, HOST_HOT_REQ, HOST_COLD_REQ, XFER_DONE, XFER_REQ, WORK_CLEAR;
	logic        RUNNING, COLD_START_BUSY, RAM_ERROR_FLAG, INNER_BOARD_FATAL_FLAG, AUTO_COLD_START_FLAG;
	logic        LOCAL_SP_SEL, MANUAL_MODE, MANIPULATED_OUTPUT_ZERO, log_clr;
	logic [1:0]  START_MODE_SETTING, HOST_MODE, XFER_OP;
	logic [11:0] HOT_START_WINDOW, log;
	logic [3:0]  EXT_TIME_MS;
	logic [16:0] OFF_TIME_S;
	logic [39:0] rows [13]; // mode, ram/flash/backup, host req, off time, flags, op log
	logic [39:0] r;
	int          i, k, cyc, fail_count, n_checks;
	pcs_start_seq #(.CYC_PER_MS(10), .MS_W(4)) pcs_start_seq_i (.*);
	pcs_xfer_model pcs_xfer_model_i (.clk(CLOCK), .rst_b(RST_B), .req(XFER_REQ), .op(XFER_OP), .done(XFER_DONE));
	// clock generator
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// op log: ended transfers, then 0 for the init step
	always @(posedge CLOCK)
		if (log_clr)
			log <= 12'h001;
		else if (XFER_REQ && XFER_DONE)
			log <= {log[9:0], XFER_OP};
		else if (WORK_CLEAR)
			log <= {log[9:0], 2'h0};
	// hang guard
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			end_sim();
		end
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// hold a supply dip of ms milliseconds, then restore the supply
	task dip(input logic dc, input logic [3:0] ext, input int ms, input logic exp);
		SUPPLY_DC <= dc;
		EXT_TIME_MS <= ext;
		SUPPLY_LOW <= 1'b1;
		repeat (ms * 10) @(posedge CLOCK);
		@(negedge CLOCK);
		check(RUNNING, exp);
		@(posedge CLOCK);
		SUPPLY_LOW <= 1'b0;
		repeat (8) @(posedge CLOCK);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial begin
		rows = '{{2'h1, 3'h6, 2'h0, 17'h0000A, 4'h1, 12'h001},
			{2'h2, 3'h6, 2'h0, 17'h0000A, 4'h1, 12'h058},
			{2'h2, 3'h2, 2'h0, 17'h0000A, 4'hB, 12'h058},
			{2'h1, 3'h2, 2'h0, 17'h0000A, 4'hB, 12'h058},
			{2'h1, 3'h5, 2'h0, 17'h0000A, 4'h3, 12'h1D8},
			{2'h2, 3'h4, 2'h0, 17'h0000A, 4'h0, 12'h001},
			{2'h1, 3'h1, 2'h0, 17'h0000A, 4'hE, 12'h001},
			{2'h2, 3'h6, 2'h0, 17'h0000A, 4'h1, 12'h058},
			{2'h1, 3'h6, 2'h0, 17'h15181, 4'h1, 12'h058},
			{2'h0, 3'h6, 2'h0, 17'h00064, 4'h1, 12'h001},
			{2'h0, 3'h6, 2'h0, 17'h00065, 4'h1, 12'h004},
			{2'h3, 3'h6, 2'h3, 17'h0000A, 4'h1, 12'h058},
			{2'h3, 3'h6, 2'h1, 17'h0000A, 4'h1, 12'h001}};
		{RST_B, SUPPLY_DC, SUPPLY_LOW, BOARD_RESTART_BIT, HOST_HOT_REQ, HOST_COLD_REQ} = 6'h00;
		{RAM_OK, FLASH_OK, BACKUP_START_OPTION} = 3'h6;
		log_clr = 1'b0;
		START_MODE_SETTING = 2'h1;
		HOST_MODE = 2'h0;
		HOT_START_WINDOW = 12'h064;
		EXT_TIME_MS = 4'h0;
		OFF_TIME_S = 17'h0000A;
		repeat (6) @(posedge CLOCK);
		RST_B <= 1'b1;
		repeat (4) @(posedge CLOCK);
		for (i = 0; i < 13; i++) begin
			r = rows[i];
			START_MODE_SETTING <= r[39:38];
			{RAM_OK, FLASH_OK, BACKUP_START_OPTION} <= r[37:35];
			{HOST_COLD_REQ, HOST_HOT_REQ} <= r[34:33];
			OFF_TIME_S <= r[32:16];
			HOST_MODE <= i[1:0];
			log_clr <= 1'b1;
			@(posedge CLOCK);
			log_clr <= 1'b0;
			BOARD_RESTART_BIT <= 1'b1;
			repeat (4) @(posedge CLOCK);
			BOARD_RESTART_BIT <= 1'b0;
			for (k = 0; k < 60 && RUNNING !== 1'b1; k++)
				@(posedge CLOCK);
			@(negedge CLOCK);
			check({RAM_ERROR_FLAG, INNER_BOARD_FATAL_FLAG, AUTO_COLD_START_FLAG, RUNNING, log}, r[15:0]);
			@(posedge CLOCK);
		end
		dip(1'b0, 4'h0, 9, 1'b1);
		dip(1'b0, 4'h0, 27, 1'b0);
		dip(1'b1, 4'h0, 1, 1'b1);
		dip(1'b1, 4'h0, 7, 1'b0);
		dip(1'b1, 4'h3, 4, 1'b1);
		dip(1'b0, 4'hA, 19, 1'b1);
		dip(1'b0, 4'hA, 37, 1'b0);
		RST_B <= 1'b0;
		repeat (2) @(negedge CLOCK);
		check({RUNNING, RAM_ERROR_FLAG, INNER_BOARD_FATAL_FLAG, AUTO_COLD_START_FLAG, XFER_REQ, WORK_CLEAR,
			COLD_START_BUSY, LOCAL_SP_SEL, MANUAL_MODE, MANIPULATED_OUTPUT_ZERO}, 16'h0007);
		// second release: host mode with hot request must reach run, flags clear
		@(posedge CLOCK);
		RST_B <= 1'b1;
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
		check({RAM_ERROR_FLAG, INNER_BOARD_FATAL_FLAG, AUTO_COLD_START_FLAG, RUNNING}, 16'h0001);
		end_sim();
	end
endmodule
`default_nettype wire
